/* src/wdr_pkg.sv */
package wdr_pkg;

	// watchdog operating modes, coded as {reset enable, irq enable}
	typedef enum logic [1:0]
	{
		WDR_STOPPED = 2'b00,
		WDR_IRQ = 2'b01,
		WDR_RESET = 2'b10,
		WDR_IRQ_RESET = 2'b11
	} wdr_mode_t;

	// stored watchdog control state
	typedef struct packed
	{
		logic irq_flag;
		logic irq_en;
		logic [3:0] period;
		logic wd_reset_enable;
	} wdr_ctl_t;

	// reset cause flags
	typedef struct packed
	{
		logic wd;
		logic bo;
		logic pin;
		logic por;
	} wdr_cause_t;

endpackage

/* src/wdr_regs.svh */
`ifndef WDR_REGS_SVH
`define WDR_REGS_SVH

// register indices; byte address is four times the index
`define WDR_IDX_CTL 6'h21
`define WDR_IDX_CAUSE 6'h20

// control register fields
`define WDR_CTL_IF 7
`define WDR_CTL_IE 6
`define WDR_CTL_P3 5
`define WDR_CTL_UNLOCK 4
`define WDR_CTL_WDE 3
`define WDR_CTL_P2 2
`define WDR_CTL_P0 0

// cause register fields
`define WDR_CAUSE_W 4
`define WDR_CAUSE_RESET 4'h1

// timing
`define WDR_UNLOCK_CYCLES 3'h4
`define WDR_BASE_CYCLES 2048
`define WDR_MAX_CODE 4'h9

// synchroniser lanes and their reset levels
`define WDR_SYNC_N 4
`define WDR_SYNC_OSC 0
`define WDR_SYNC_BO 1
`define WDR_SYNC_PIN 2
`define WDR_SYNC_FUSE 3
`define WDR_SYNC_RESET 4'h8

`endif

/* src/wdr_top.sv */
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "wdr_regs.svh"

module wdr_top
	import wdr_pkg::*;
#(
	parameter int BASE_CYCLES = `WDR_BASE_CYCLES,
	parameter int CNT_W = 21
)
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic wd_osc_in,
	input wire logic brownout_reset_in,
	input wire logic pin_reset_in,
	input wire logic wd_forced_on_fuse,
	input wire logic wd_restart,
	input wire logic wd_vector_taken,
	input wire logic global_irq_enable,
	output logic wd_irq_req,
	output logic sys_reset_pulse
);

	// *******************************************************
	// elaboration checks
	// *******************************************************

	// the longest period must fit the counter, and the base must be a power of two
	if (BASE_CYCLES < 1 || (BASE_CYCLES & (BASE_CYCLES - 1)) != 0)
		$error("BASE_CYCLES must be a power of two");
	if ($clog2(BASE_CYCLES) + 10 > CNT_W)
		$error("CNT_W too small for the longest period");

	// *******************************************************
	// helpers
	// *******************************************************

	// register select from a byte address; unmapped gives 2'b00
	function automatic logic [1:0] reg_sel(input logic [7:0] addr);
		logic [1:0] s;
		s = 2'b00;
		if (addr[1:0] == 2'b00)
		begin
			if (addr[7:2] == `WDR_IDX_CTL)
				s = 2'b01;
			else if (addr[7:2] == `WDR_IDX_CAUSE)
				s = 2'b10;
		end
		return s;
	endfunction

	// counter value at which the selected period expires
	function automatic logic [CNT_W-1:0] period_last(input logic [3:0] code);
		logic [3:0] c;
		c = code;
		// reserved codes behave as the longest period
		if (c > `WDR_MAX_CODE)
			c = `WDR_MAX_CODE;
		return (CNT_W'(BASE_CYCLES) << c) - CNT_W'(1);
	endfunction

	// period field is split over bits 5 and 2:0
	function automatic logic [3:0] period_field(input logic [7:0] d);
		return {d[`WDR_CTL_P3], d[`WDR_CTL_P2:`WDR_CTL_P0]};
	endfunction

	// *******************************************************
	// input synchronisers
	// *******************************************************

	// per-lane reset levels; the fuse lane idles unprogrammed
	localparam logic [`WDR_SYNC_N-1:0] SYNC_RST = `WDR_SYNC_RESET;

	logic [`WDR_SYNC_N-1:0] async_in;
	logic [`WDR_SYNC_N-1:0] level;
	logic [`WDR_SYNC_N-1:0] rise;

	assign async_in = {wd_forced_on_fuse, pin_reset_in, brownout_reset_in, wd_osc_in};

	// three stages; a change counts once stages two and three agree
	for (genvar i = 0; i < `WDR_SYNC_N; i++)
	begin : g_sync
		logic s1_ff;
		logic s2_ff;
		logic s3_ff;
		logic filt_ff;
		logic nxt_filt;

		// filtered level only moves when the last two stages agree
		always_comb
		begin
			nxt_filt = (s2_ff == s3_ff) ? s3_ff : filt_ff;
		end

		// fuse lane resets to unprogrammed until its level is caught
		always_ff @(posedge clock or negedge rstn)
		begin
			if (!rstn)
			begin
				s1_ff <= SYNC_RST[i];
				s2_ff <= SYNC_RST[i];
				s3_ff <= SYNC_RST[i];
				filt_ff <= SYNC_RST[i];
			end
			else
			begin
				s1_ff <= async_in[i];
				s2_ff <= s1_ff;
				s3_ff <= s2_ff;
				filt_ff <= nxt_filt;
			end
		end

		assign level[i] = filt_ff;
		assign rise[i] = nxt_filt & ~filt_ff;
	end

	logic osc_tick;
	logic bo_evt;
	logic pin_evt;
	logic fuse_prog;

	assign osc_tick = rise[`WDR_SYNC_OSC];
	assign bo_evt = rise[`WDR_SYNC_BO];
	assign pin_evt = rise[`WDR_SYNC_PIN];
	// the fuse reads zero when programmed
	assign fuse_prog = ~level[`WDR_SYNC_FUSE];

	// *******************************************************
	// avalon slave
	// *******************************************************

	logic wait_ff;
	logic nxt_wait;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic [1:0] sel;
	logic commit;
	logic wr_ctl;
	logic wr_cause;
	logic [7:0] wdat;
	logic [7:0] ctl_view;
	logic [7:0] cause_view;

	wdr_ctl_t ctl_ff;
	wdr_cause_t cause_ff;
	logic [2:0] unlock_ff;

	assign sel = reg_sel(avs_address);
	assign wdat = avs_writedata[7:0];
	// a request is answered one cycle after it is seen; this edge completes it
	assign commit = avs_write & ~wait_ff & avs_byteenable[0];
	assign wr_ctl = commit & (sel == 2'b01);
	assign wr_cause = commit & (sel == 2'b10);

	// readback; reset enable reads as forced while the fuse or flag holds it
	assign ctl_view = {ctl_ff.irq_flag, ctl_ff.irq_en & ~fuse_prog, ctl_ff.period[3],
		unlock_ff != 3'h0, ctl_ff.wd_reset_enable | fuse_prog, ctl_ff.period[2:0]};
	assign cause_view = {4'h0, cause_ff};

	// fixed one-cycle answer keeps the master logic trivial
	always_comb
	begin
		nxt_wait = 1'b1;
		nxt_rdata = rdata_ff;
		if (wait_ff && (avs_read || avs_write))
		begin
			nxt_wait = 1'b0;
			if (avs_read)
			begin
				case (sel)
					2'b01: nxt_rdata = {24'h000000, ctl_view};
					2'b10: nxt_rdata = {24'h000000, cause_view};
					default: nxt_rdata = 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			wait_ff <= 1'b1;
			rdata_ff <= 32'h00000000;
		end
		else
		begin
			wait_ff <= nxt_wait;
			rdata_ff <= nxt_rdata;
		end
	end

	assign avs_waitrequest = wait_ff;
	assign avs_readdata = rdata_ff;

	// *******************************************************
	// watchdog control
	// *******************************************************

	wdr_ctl_t nxt_ctl;
	wdr_cause_t nxt_cause;
	logic [2:0] nxt_unlock;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic irq_req_ff;
	logic nxt_irq_req;
	logic rst_pulse_ff;
	logic nxt_rst_pulse;
	wdr_mode_t mode;
	logic timeout;

	// the fuse overrides the enables
	always_comb
	begin
		if (fuse_prog)
			mode = WDR_RESET;
		else
		begin
			case ({ctl_ff.wd_reset_enable, ctl_ff.irq_en})
				2'b00: mode = WDR_STOPPED;
				2'b01: mode = WDR_IRQ;
				2'b10: mode = WDR_RESET;
				2'b11: mode = WDR_IRQ_RESET;
				default: mode = WDR_STOPPED;
			endcase
		end
	end

	// >= so that a shorter period set mid-count expires on the next oscillator tick
	assign timeout = osc_tick & (mode != WDR_STOPPED) & ~wd_restart
		& (cnt_ff >= period_last(ctl_ff.period));

	always_comb
	begin
		nxt_ctl = ctl_ff;
		nxt_cause = cause_ff;
		nxt_unlock = unlock_ff;
		nxt_cnt = cnt_ff;
		nxt_rst_pulse = 1'b0;

		// unlock window runs down on system clocks
		if (unlock_ff != 3'h0)
			nxt_unlock = unlock_ff - 3'h1;

		// software write to control
		if (wr_ctl)
		begin
			if (wdat[`WDR_CTL_UNLOCK])
			begin
				nxt_unlock = `WDR_UNLOCK_CYCLES;
				if (wdat[`WDR_CTL_WDE])
					nxt_ctl.wd_reset_enable = 1'b1;
			end
			else if (unlock_ff != 3'h0)
			begin
				nxt_ctl.wd_reset_enable = wdat[`WDR_CTL_WDE];
				nxt_ctl.period = period_field(wdat);
			end
			else if (wdat[`WDR_CTL_WDE])
				nxt_ctl.wd_reset_enable = 1'b1; // setting needs no unlock
			nxt_ctl.irq_en = wdat[`WDR_CTL_IE];
			if (wdat[`WDR_CTL_IF])
				nxt_ctl.irq_flag = 1'b0;
		end

		// writing zero clears a cause flag, writing one leaves it
		if (wr_cause)
			nxt_cause = cause_ff & wdat[`WDR_CAUSE_W-1:0];

		// vector taken clears the flag, and the enable in combined mode
		if (wd_vector_taken)
		begin
			nxt_ctl.irq_flag = 1'b0;
			if (mode == WDR_IRQ_RESET)
				nxt_ctl.irq_en = 1'b0;
		end

		// counter: restart, clear when stopped, else count oscillator ticks
		if (wd_restart || mode == WDR_STOPPED)
			nxt_cnt = '0;
		else if (timeout)
			nxt_cnt = '0;
		else if (osc_tick)
			nxt_cnt = cnt_ff + CNT_W'(1);

		// time-out action; sets win over any clear in the same cycle
		if (timeout)
		begin
			case (mode)
				WDR_IRQ: nxt_ctl.irq_flag = 1'b1;
				WDR_RESET: nxt_rst_pulse = 1'b1;
				WDR_IRQ_RESET:
				begin
					if (ctl_ff.irq_flag)
						nxt_rst_pulse = 1'b1;
					else
						nxt_ctl.irq_flag = 1'b1;
				end
				default: nxt_rst_pulse = 1'b0;
			endcase
		end

		// cause events
		if (nxt_rst_pulse)
			nxt_cause.wd = 1'b1;
		if (bo_evt)
			nxt_cause.bo = 1'b1;
		if (pin_evt)
			nxt_cause.pin = 1'b1;

		// a set flag or the fuse pins reset enable high
		if (nxt_cause.wd || fuse_prog)
			nxt_ctl.wd_reset_enable = 1'b1;
		if (fuse_prog)
			nxt_ctl.irq_en = 1'b0;

		nxt_irq_req = nxt_ctl.irq_flag & nxt_ctl.irq_en & global_irq_enable;
	end

	// rstn is the power-on reset: only it sets the power-on flag
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			ctl_ff <= '0;
			cause_ff <= `WDR_CAUSE_RESET;
			unlock_ff <= 3'h0;
			cnt_ff <= '0;
			irq_req_ff <= 1'b0;
			rst_pulse_ff <= 1'b0;
		end
		else
		begin
			ctl_ff <= nxt_ctl;
			cause_ff <= nxt_cause;
			unlock_ff <= nxt_unlock;
			cnt_ff <= nxt_cnt;
			irq_req_ff <= nxt_irq_req;
			rst_pulse_ff <= nxt_rst_pulse;
		end
	end

	assign wd_irq_req = irq_req_ff;
	assign sys_reset_pulse = rst_pulse_ff;

endmodule

/* tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] avs_address = 8'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic osc = 1'b0;
	logic bo = 1'b0;
	logic pin = 1'b0;
	logic fuse = 1'b1;
	logic restart = 1'b0;
	logic gie = 1'b0;
	logic serve = 1'b0;
	logic [3:0] be = 4'hf;
	int pulses = 0;
	logic vec;
	logic irq;
	logic pulse;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	int n;
	// ****************
	// harness
	// ****************
	always #10 clock = !clock;
	always #3906 osc = !osc; // free running, near 128 kHz
	// small base keeps time-outs to a few thousand cycles
	wdr_top #(.BASE_CYCLES(4)) u_wdr_top (.clock(clock), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(be), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.wd_osc_in(osc), .brownout_reset_in(bo), .pin_reset_in(pin),
		.wd_forced_on_fuse(fuse), .wd_restart(restart), .wd_vector_taken(vec),
		.global_irq_enable(gie), .wd_irq_req(irq), .sys_reset_pulse(pulse));
	wdr_core_model u_wdr_core_model (.clock(clock), .rstn(rstn), .serve(serve),
		.wd_irq_req(irq), .wd_vector_taken(vec));
	task automatic conclude;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp)
		begin
			$display("mismatch %s expected %h seen %h", what, exp, got);
			num_errors++;
		end
	endtask
	// request held until waitrequest is seen low, then one idle edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_read <= !wr;
		avs_write <= wr;
		do
			@(posedge clock);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clock);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input string what, input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] exp);
		logic [7:0] q;
		bus(1'b0, a, 8'h0, q);
		chk(what, exp, q & m);
	endtask
	// pulses restart, pin reset, brown-out as {restart, pin, bo}
	task automatic strobe(input logic [2:0] sel);
		{restart, pin, bo} <= sel;
		repeat (6) @(posedge clock);
		{restart, pin, bo} <= 3'h0;
		repeat (6) @(posedge clock);
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_cause;
		rd("cause", 8'h80, 8'hff, 8'h01);
		rd("control", 8'h84, 8'hff, 8'h00);
		rd("unmapped", 8'h88, 8'hff, 8'h00);
		wr(8'h80, 8'h00);
		strobe(3'h2);
		rd("pin", 8'h80, 8'hff, 8'h02);
		strobe(3'h1);
		rd("brownout", 8'h80, 8'hff, 8'h06);
		// a write without its low byte lane must leave the flags alone
		be <= 4'he;
		wr(8'h80, 8'h00);
		be <= 4'hf;
		rd("lane off", 8'h80, 8'hff, 8'h06);
		wr(8'h80, 8'h04);
		rd("pin clr", 8'h80, 8'hff, 8'h04);
		wr(8'h80, 8'h00);
		rd("bo clr", 8'h80, 8'hff, 8'h00);
	endtask
	task automatic t_reset_mode;
		wr(8'h84, 8'h08);
		wr(8'h84, 8'h09);
		rd("locked", 8'h84, 8'hef, 8'h08);
		strobe(3'h4);
		wr(8'h84, 8'h18);
		wr(8'h84, 8'h09);
		rd("unlocked", 8'h84, 8'hef, 8'h09);
		// restarts well inside the period must keep the pulse away
		n = pulses;
		repeat (3)
		begin
			strobe(3'h4);
			repeat (2000) @(posedge clock);
		end
		chk("no timeout", 8'h00, 8'(pulses - n));
		strobe(3'h4);
		n = 0;
		while (pulse !== 1'b1)
		begin
			@(posedge clock);
			n++;
		end
		chk("period", 8'h01, {7'h0, n > 2600 && n < 3600});
		rd("wd flag", 8'h80, 8'hff, 8'h08);
	endtask
	task automatic t_lock;
		strobe(3'h4);
		wr(8'h84, 8'h18);
		wr(8'h84, 8'h00);
		rd("held", 8'h84, 8'hef, 8'h08);
		wr(8'h80, 8'h00);
		wr(8'h84, 8'h18);
		repeat (8) @(posedge clock);
		wr(8'h84, 8'h00);
		rd("late", 8'h84, 8'hef, 8'h08);
		wr(8'h84, 8'h18);
		wr(8'h84, 8'h00);
		rd("off", 8'h84, 8'hef, 8'h00);
	endtask
	task automatic t_irq;
		gie <= 1'b1;
		wr(8'h84, 8'h40);
		strobe(3'h4);
		while (irq !== 1'b1)
			@(posedge clock);
		rd("irq flag", 8'h84, 8'hff, 8'hc0);
		gie <= 1'b0;
		repeat (3) @(posedge clock);
		chk("masked", 8'h00, {7'h0, irq});
		wr(8'h84, 8'hc0);
		rd("flag clr", 8'h84, 8'hff, 8'h40);
	endtask
	// unserved first time-out must end in a reset, then the vector strips the enable
	task automatic t_combined;
		gie <= 1'b1;
		wr(8'h84, 8'h48);
		strobe(3'h4);
		while (irq !== 1'b1)
			@(posedge clock);
		while (pulse !== 1'b1)
			@(posedge clock);
		rd("combined", 8'h84, 8'hff, 8'hc8);
		serve <= 1'b1;
		repeat (6) @(posedge clock);
		rd("vector", 8'h84, 8'hef, 8'h08);
	endtask
	// a second power-on clears the other cause flags and the control register
	task automatic t_por;
		rstn <= 1'b0;
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		rd("por cause", 8'h80, 8'hff, 8'h01);
		rd("por control", 8'h84, 8'hef, 8'h00);
	endtask
	task automatic t_fuse;
		fuse <= 1'b0;
		repeat (10) @(posedge clock);
		wr(8'h84, 8'h40);
		rd("fuse", 8'h84, 8'h48, 8'h08);
	endtask
	// reset pulses seen, to prove that timely restarts hold them off
	always @(posedge clock)
	begin
		if (pulse === 1'b1)
			pulses++;
	end
	// hang guard, well above the few time-outs waited for
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			num_errors++;
			conclude();
		end
	end
	initial
	begin
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		t_cause();
		t_reset_mode();
		t_lock();
		t_irq();
		t_combined();
		t_por();
		t_fuse();
		conclude();
	end
endmodule

/* tb/wdr_core_model.sv */
`timescale 1ns/1ns
module wdr_core_model
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic serve,
	input wire logic wd_irq_req,
	output logic wd_vector_taken
);
	// ****************
	// interrupt entry
	// ****************
	logic [1:0] lat_ff;
	// vector runs two cycles after a request; serve low models a core that never gets there
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			lat_ff <= 2'h0;
		else if (serve && wd_irq_req && !wd_vector_taken)
			lat_ff <= lat_ff + 2'h1;
		else
			lat_ff <= 2'h0;
	end
	assign wd_vector_taken = lat_ff == 2'h2;
endmodule

/* tb/wdr_props.sv */
`timescale 1ns/1ns
module wdr_props
	import wdr_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic wd_forced_on_fuse,
	input wire logic wd_vector_taken,
	input wire logic global_irq_enable,
	input wire logic wd_irq_req,
	input wire logic sys_reset_pulse
);
	// ****************
	// port checks
	// ****************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	// a request seen while the slave still waits
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_cause_rd;
		avs_read && avs_waitrequest && avs_address == 8'h80 ##1 !avs_waitrequest;
	endsequence
	a_wait_one_cycle: assert property (s_req |=> !avs_waitrequest)
		else $error("no answer one cycle after request");
	a_wait_rearms: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_cause_upper_zero: assert property (s_cause_rd |-> avs_readdata[31:4] == 28'h0)
		else $error("reserved cause bits not zero");
	a_pulse_one_cycle: assert property (sys_reset_pulse |=> !sys_reset_pulse)
		else $error("reset pulse longer than one cycle");
	a_irq_needs_gie: assert property (wd_irq_req |-> $past(global_irq_enable))
		else $error("request without global enable");
	a_gie_off_quiet: assert property ($fell(global_irq_enable) |=> !wd_irq_req [*3])
		else $error("request stays after global disable");
	a_vector_clears: assert property (wd_vector_taken |-> ##2 !wd_irq_req)
		else $error("request stays after vector");
	// the fuse crosses a synchroniser, so allow it a few cycles to bite
	a_fuse_no_irq: assert property (!wd_forced_on_fuse [*8] |-> !wd_irq_req)
		else $error("request while fuse forces reset mode");
endmodule

bind wdr_top wdr_props u_props (.clock, .rstn, .avs_address, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest, .wd_forced_on_fuse, .wd_vector_taken,
	.global_irq_enable, .wd_irq_req, .sys_reset_pulse);
